// File: rtl/rscl_top.sv
// How it works
// - straps are sampled only while the global reset input is low.
// - local memory strap high selects 133 MHz, low selects 100 MHz.
// - host frequency strap low means 100 MHz; high is reserved and flagged.
// - queue depth strap high gives depth 4, low gives depth 1.
// - float strap low floats the strap pins and the cache clock outputs; high is normal operation.
// - kicker strap low selects the supported processors; high is flagged.
// - stop-mode strap high selects stop-grant, low selects quick-start.
// - system memory strap pins get a weak pull-up request during reset.
// - all derived clocks use the 100 MHz host clock as their reference.
// - two cache transmit clocks are made inside and driven out.
// - a loop-out clock is driven and the returned clock captures read data.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`default_nettype none
module rscl_top
  import rscl_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int CACHE_DW = 16
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RST_N,
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  input  wire logic                WB_WE_I,
  input  wire logic [ADDR_W-1:0]   WB_ADR_I,
  input  wire logic [3:0]          WB_SEL_I,
  input  wire logic [31:0]         WB_DAT_I,
  output logic      [31:0]         WB_DAT_O,
  output logic                     WB_ACK_O,
  input  wire logic                GLOBAL_RESET_N,
  input  wire logic                LMEM_FREQ_STRAP_PIN,
  input  wire logic [4:0]          SMEM_STRAP_PIN_I,
  output logic      [4:0]          SMEM_STRAP_PIN_O,
  output logic      [4:0]          SMEM_STRAP_PIN_OE,
  output logic                     SMEM_PULLUP_EN,
  input  wire logic [4:0]          CORE_SMEM_O,
  input  wire logic [4:0]          CORE_SMEM_OE,
  output logic                     LMEM_FREQ_133,
  output logic                     HOST_FREQ_100,
  output logic [2:0]               IN_ORDER_QUEUE_DEPTH,
  output logic                     FLOAT_ALL,
  output logic                     STOP_GRANT_SEL,
  output logic                     CONFIG_VALID,
  output logic                     STRAP_RESERVED_ERR,
  output logic [1:0]               CACHE_TRANSMIT_CLOCKS,
  output logic                     CACHE_LOOP_OUT_CLOCK,
  output logic                     CACHE_CLK_OE,
  input  wire logic                CACHE_RECEIVE_CLOCK,
  input  wire logic [CACHE_DW-1:0] CACHE_RD_DATA,
  output logic [CACHE_DW-1:0]      CACHE_RD_Q,
  output logic                     CACHE_RD_VALID
);

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,
    ST_HOLD   = 2'b10
  } rscl_state_e;

  function automatic logic [31:0] rscl_zext6(input logic [5:0] v);
    rscl_zext6 = {26'h0, v};
  endfunction : rscl_zext6

  rscl_state_e           state_q;
  rscl_state_e           state_d;
  logic                  grst_n_s;
  logic [STRAP_W-1:0]    pins_s;
  logic [STRAP_W-1:0]    strap_q;
  logic                  valid_q;
  logic                  cc_en_q;
  logic [CC_DIV_W-1:0]   cc_div_q;
  logic [CC_DIV_W-1:0]   div_cnt_q;
  logic                  div_clk_q;
  logic                  rx_clk_s;
  logic                  rx_clk_prev_q;
  logic [CACHE_DW-1:0]   rx_data_s;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic                  req;
  logic                  wr_req;
  logic [ADDR_W-1:0]     reg_addr;
  logic                  float_on;
  logic                  sampling;
  logic                  host_rsv;
  logic                  kick_rsv;
  logic [31:0]           status_word;
  logic [31:0]           clkctl_word;
  logic [31:0]           pins_word;
  logic [31:0]           rd_word;

  // pin synchronisers
  rscl_sync #(
    .W    (1 + STRAP_W),
    .INIT ({1'b0, STRAP_RESET_VAL})
  ) u_pin_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .din   ({GLOBAL_RESET_N, SMEM_STRAP_PIN_I[4], SMEM_STRAP_PIN_I[3],
             SMEM_STRAP_PIN_I[2], SMEM_STRAP_PIN_I[1],
             SMEM_STRAP_PIN_I[0], LMEM_FREQ_STRAP_PIN}),
    .dout  ({grst_n_s, pins_s})
  );

  rscl_sync #(
    .W    (1 + CACHE_DW),
    .INIT ('0)
  ) u_rx_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .din   ({CACHE_RECEIVE_CLOCK, CACHE_RD_DATA}),
    .dout  ({rx_clk_s, rx_data_s})
  );

  // latch sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SAMPLE: begin
        if (grst_n_s) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!grst_n_s) begin
          state_d = ST_SAMPLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= ST_SAMPLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign sampling = (state_q == ST_SAMPLE);

  // strap capture
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      strap_q <= STRAP_RESET_VAL;
    end else if (sampling && !grst_n_s) begin
      strap_q <= pins_s;
    end
  end

  // valid flag
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      valid_q <= 1'b0;
    end else if (state_q == ST_SAMPLE) begin
      valid_q <= grst_n_s;
    end
  end

  // decoded settings
  // local memory rate
  assign LMEM_FREQ_133 = strap_q[STRAP_LMEM_BIT];
  assign HOST_FREQ_100 = ~strap_q[STRAP_HOST_BIT];
  assign host_rsv      = strap_q[STRAP_HOST_BIT];
  assign IN_ORDER_QUEUE_DEPTH = strap_q[STRAP_IOQ_BIT] ? IOQ_DEEP
                                                       : IOQ_SHALLOW;
  assign float_on  = valid_q & ~strap_q[STRAP_FLOAT_BIT];
  assign FLOAT_ALL = float_on;
  assign kick_rsv  = strap_q[STRAP_KICK_BIT];
  assign STOP_GRANT_SEL     = strap_q[STRAP_STOP_BIT];
  assign CONFIG_VALID       = valid_q;
  assign STRAP_RESERVED_ERR = valid_q & (host_rsv | kick_rsv);

  // shared pin drive
  // weak pull during reset
  assign SMEM_PULLUP_EN    = sampling;
  assign SMEM_STRAP_PIN_O  = CORE_SMEM_O;
  assign SMEM_STRAP_PIN_OE = (sampling || float_on) ? 5'h00 : CORE_SMEM_OE;

  // cache clock divider
  // host clock reference
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      div_cnt_q <= CC_DIV_RESET;
      div_clk_q <= 1'b0;
    end else if (!cc_en_q) begin
      div_cnt_q <= CC_DIV_RESET;
      div_clk_q <= 1'b0;
    end else if (div_cnt_q >= cc_div_q) begin
      div_cnt_q <= CC_DIV_RESET;
      div_clk_q <= ~div_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  assign CACHE_TRANSMIT_CLOCKS = {div_clk_q, div_clk_q};
  assign CACHE_LOOP_OUT_CLOCK  = div_clk_q;
  assign CACHE_CLK_OE          = cc_en_q & ~float_on;

  // receive capture
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_clk_prev_q <= 1'b0;
    end else begin
      rx_clk_prev_q <= rx_clk_s;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      CACHE_RD_Q     <= '0;
      CACHE_RD_VALID <= 1'b0;
    end else begin
      CACHE_RD_VALID <= rx_clk_s & ~rx_clk_prev_q;
      if (rx_clk_s && !rx_clk_prev_q) begin
        CACHE_RD_Q <= rx_data_s;
      end
    end
  end

  // wishbone slave
  assign req      = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr_req   = req & WB_WE_I;
  assign reg_addr = {WB_ADR_I[ADDR_W-1:2], 2'b00};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // clock control register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cc_en_q  <= CC_EN_RESET;
      cc_div_q <= CC_DIV_RESET;
    end else if (wr_req && reg_addr == REG_CLK_CTRL && WB_SEL_I[0]) begin
      cc_en_q  <= WB_DAT_I[CC_EN_BIT];
      cc_div_q <= WB_DAT_I[CC_DIV_LSB +: CC_DIV_W];
    end
  end

  always_comb begin
    status_word = rscl_zext6(strap_q);
    status_word[ST_VALID_BIT]    = valid_q;
    status_word[ST_HOST_RSV_BIT] = valid_q & host_rsv;
    status_word[ST_KICK_RSV_BIT] = valid_q & kick_rsv;
    status_word[ST_FLOAT_ON_BIT] = float_on;
  end

  always_comb begin
    clkctl_word = 32'h0;
    clkctl_word[CC_EN_BIT] = cc_en_q;
    clkctl_word[CC_DIV_LSB +: CC_DIV_W] = cc_div_q;
  end

  always_comb begin
    pins_word = rscl_zext6(pins_s);
    pins_word[PS_GRST_BIT]     = grst_n_s;
    pins_word[PS_SAMPLING_BIT] = sampling;
  end

  // read mux, unmapped reads zero
  always_comb begin
    rd_word = 32'h0;
    if (reg_addr == REG_STRAP_STATUS) begin
      rd_word = status_word;
    end else if (reg_addr == REG_CLK_CTRL) begin
      rd_word = clkctl_word;
    end else if (reg_addr == REG_PIN_STATUS) begin
      rd_word = pins_word;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dat_q <= 32'h0;
    end else if (req && !WB_WE_I) begin
      dat_q <= rd_word;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

endmodule : rscl_top
`default_nettype wire

// File: rtl/rscl_pkg.sv
`default_nettype none
package rscl_pkg;
  // strap vector positions
  localparam int STRAP_LMEM_BIT   = 0;
  localparam int STRAP_HOST_BIT   = 1;
  localparam int STRAP_IOQ_BIT    = 2;
  localparam int STRAP_FLOAT_BIT  = 3;
  localparam int STRAP_KICK_BIT   = 4;
  localparam int STRAP_STOP_BIT   = 5;
  localparam int STRAP_W          = 6;
  // value of each strap when nothing was sampled yet
  localparam logic [5:0] STRAP_RESET_VAL = 6'h2D;
  // register byte offsets
  localparam logic [7:0] REG_STRAP_STATUS = 8'h00;
  localparam logic [7:0] REG_CLK_CTRL     = 8'h04;
  localparam logic [7:0] REG_PIN_STATUS   = 8'h08;
  // status field positions
  localparam int ST_VALID_BIT     = 8;
  localparam int ST_HOST_RSV_BIT  = 9;
  localparam int ST_KICK_RSV_BIT  = 10;
  localparam int ST_FLOAT_ON_BIT  = 12;
  localparam int PS_GRST_BIT      = 8;
  localparam int PS_SAMPLING_BIT  = 9;
  // clock control fields
  localparam int CC_EN_BIT        = 0;
  localparam int CC_DIV_LSB       = 4;
  localparam int CC_DIV_W         = 4;
  localparam logic [0:0] CC_EN_RESET  = 1'h1;
  localparam logic [3:0] CC_DIV_RESET = 4'h0;
  // frequency and depth encodings
  localparam int HOST_CLK_MHZ     = 100;
  localparam int LMEM_FAST_MHZ    = 133;
  localparam int LMEM_SLOW_MHZ    = 100;
  localparam logic [2:0] IOQ_DEEP    = 3'h4;
  localparam logic [2:0] IOQ_SHALLOW = 3'h1;
  localparam int SYNC_STAGES      = 2;
endpackage : rscl_pkg
`default_nettype wire

// File: rtl/rscl_sync.sv
`default_nettype none
module rscl_sync
  import rscl_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // two flops per bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : rscl_sync
`default_nettype wire

// File: bench/rscl_chk.sv
`default_nettype none
module rscl_chk
  import rscl_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       GLOBAL_RESET_N,
  input wire logic       LMEM_FREQ_STRAP_PIN,
  input wire logic [4:0] SMEM_STRAP_PIN_I,
  input wire logic [4:0] SMEM_STRAP_PIN_OE,
  input wire logic       SMEM_PULLUP_EN,
  input wire logic       LMEM_FREQ_133,
  input wire logic       HOST_FREQ_100,
  input wire logic [2:0] IN_ORDER_QUEUE_DEPTH,
  input wire logic       FLOAT_ALL,
  input wire logic       STOP_GRANT_SEL,
  input wire logic       CONFIG_VALID,
  input wire logic       STRAP_RESERVED_ERR,
  input wire logic       CACHE_CLK_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  strap_follow_a: assert property (
    (!GLOBAL_RESET_N && $stable({LMEM_FREQ_STRAP_PIN, SMEM_STRAP_PIN_I}))[*6]
    |-> LMEM_FREQ_133 == LMEM_FREQ_STRAP_PIN
        && STOP_GRANT_SEL == SMEM_STRAP_PIN_I[4]
        && IN_ORDER_QUEUE_DEPTH == (SMEM_STRAP_PIN_I[1] ? 3'h4 : 3'h1))
    else $error("straps do not follow pins");
  host_rsv_a: assert property (
    CONFIG_VALID && !HOST_FREQ_100 |-> STRAP_RESERVED_ERR)
    else $error("reserved host strap not flagged");
  float_off_a: assert property (
    FLOAT_ALL |-> CONFIG_VALID && SMEM_STRAP_PIN_OE == 5'h00 && !CACHE_CLK_OE)
    else $error("float mode still drives");
  pull_on_a: assert property (
    !GLOBAL_RESET_N [*4] |-> SMEM_PULLUP_EN && SMEM_STRAP_PIN_OE == 5'h00)
    else $error("no pull-up in reset");
  pull_off_a: assert property (
    (GLOBAL_RESET_N && CONFIG_VALID) [*6] |-> !SMEM_PULLUP_EN)
    else $error("pull-up after reset");
  latch_hold_a: assert property (
    (GLOBAL_RESET_N && CONFIG_VALID) [*6] |-> $stable({LMEM_FREQ_133,
      HOST_FREQ_100, IN_ORDER_QUEUE_DEPTH, FLOAT_ALL, STOP_GRANT_SEL}))
    else $error("latched straps moved");
  valid_rise_a: assert property (
    $rose(GLOBAL_RESET_N) |-> ##[2:4] CONFIG_VALID)
    else $error("config valid late");
  depth_enc_a: assert property (
    IN_ORDER_QUEUE_DEPTH == 3'h4 || IN_ORDER_QUEUE_DEPTH == 3'h1)
    else $error("bad queue depth");
  cover property ($rose(CONFIG_VALID));
  cover property (FLOAT_ALL);
  cover property (STRAP_RESERVED_ERR);
endmodule : rscl_chk
bind rscl_top rscl_chk rscl_chk_inst (
  .CORE_CLK             (CORE_CLK),
  .RST_N                (RST_N),
  .GLOBAL_RESET_N       (GLOBAL_RESET_N),
  .LMEM_FREQ_STRAP_PIN  (LMEM_FREQ_STRAP_PIN),
  .SMEM_STRAP_PIN_I     (SMEM_STRAP_PIN_I),
  .SMEM_STRAP_PIN_OE    (SMEM_STRAP_PIN_OE),
  .SMEM_PULLUP_EN       (SMEM_PULLUP_EN),
  .LMEM_FREQ_133        (LMEM_FREQ_133),
  .HOST_FREQ_100        (HOST_FREQ_100),
  .IN_ORDER_QUEUE_DEPTH (IN_ORDER_QUEUE_DEPTH),
  .FLOAT_ALL            (FLOAT_ALL),
  .STOP_GRANT_SEL       (STOP_GRANT_SEL),
  .CONFIG_VALID         (CONFIG_VALID),
  .STRAP_RESERVED_ERR   (STRAP_RESERVED_ERR),
  .CACHE_CLK_OE         (CACHE_CLK_OE)
);
`default_nettype wire

// File: bench/rscl_board.sv
`default_nettype none
module rscl_board (
  input  wire logic       clk,
  input  wire logic       pci_rst,
  input  wire logic [5:0] strap,
  input  wire logic [4:0] drv,
  input  wire logic       pull_en,
  input  wire logic [4:0] dev_o,
  input  wire logic [4:0] dev_oe,
  output logic            grst_n,
  output logic            lmem_pin,
  output logic [4:0]      pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_q = 1'h0;
  always_ff @(posedge clk) grst_n <= !pci_rst;
  always_ff @(posedge clk) flip_q <= !flip_q;
  assign lmem_pin = strap[0];
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (dev_oe[i]) pins[i] = dev_o[i];
      else if (drv[i]) pins[i] = strap[i+1];
      else if (pull_en) pins[i] = 1'h1;
      else pins[i] = flip_q ^ i[0];
    end
  end
endmodule : rscl_board
`default_nettype wire

// File: bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rscl_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic        pci_rst = 1'h1, rclk = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat;
  logic [5:0]  strap = 6'h2D;
  logic [4:0]  drv = 5'h1F, core_o = 5'h00, core_oe = 5'h00;
  logic [4:0]  pins, pin_o, pin_oe;
  logic [15:0] rdata = 16'h0, rq;
  logic [2:0]  depth;
  logic        ack, grst_n, lmem_pin, pull, l133, h100, flt, stopg;
  logic        valid, rsv, rvalid;
  logic [1:0]  tx;
  logic        lo, coe;
  int          error_cnt = 0, comparisons = 0;
  always #5 clk = ~clk;
  rscl_board rscl_board_inst (.clk(clk), .pci_rst(pci_rst), .strap(strap),
    .drv(drv), .pull_en(pull), .dev_o(pin_o), .dev_oe(pin_oe),
    .grst_n(grst_n), .lmem_pin(lmem_pin), .pins(pins));
  rscl_top rscl_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .GLOBAL_RESET_N(grst_n), .LMEM_FREQ_STRAP_PIN(lmem_pin),
    .SMEM_STRAP_PIN_I(pins), .SMEM_STRAP_PIN_O(pin_o),
    .SMEM_STRAP_PIN_OE(pin_oe), .SMEM_PULLUP_EN(pull),
    .CORE_SMEM_O(core_o), .CORE_SMEM_OE(core_oe), .LMEM_FREQ_133(l133),
    .HOST_FREQ_100(h100), .IN_ORDER_QUEUE_DEPTH(depth), .FLOAT_ALL(flt),
    .STOP_GRANT_SEL(stopg), .CONFIG_VALID(valid), .STRAP_RESERVED_ERR(rsv),
    .CACHE_TRANSMIT_CLOCKS(tx), .CACHE_LOOP_OUT_CLOCK(lo), .CACHE_CLK_OE(coe),
    .CACHE_RECEIVE_CLOCK(rclk), .CACHE_RD_DATA(rdata), .CACHE_RD_Q(rq),
    .CACHE_RD_VALID(rvalid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    logic [31:0] q;
    logic [5:0]  eff;
    logic        lo_prev;
    int          rises;
    int          exp_q[$];
    void'($urandom(64165));
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    wb(1'h0, REG_CLK_CTRL, 32'h0, 4'hF, q);
    check(q, {24'h0, CC_DIV_RESET, 3'h0, CC_EN_RESET});
    wb(1'h1, REG_CLK_CTRL, 32'hFFFF_FFF2, 4'hF, q);
    wb(1'h0, REG_CLK_CTRL, 32'h0, 4'hF, q);
    check(q, 32'hF0);
    wb(1'h0, 8'h0C, 32'h0, 4'hF, q);
    check(q, 32'h0);
    for (int n = 0; n < 12; n++) begin
      strap <= n == 0 ? 6'h2D : 6'($urandom);
      drv <= n == 0 ? 5'h1F : 5'($urandom);
      core_o <= 5'($urandom);
      core_oe <= 5'($urandom);
      pci_rst <= 1'h1;
      repeat (12) @(posedge clk);
      check({pull, pin_oe}, 6'h20);
      eff = strap | {~drv, 1'h0};
      exp_q.push_back({19'h0, !eff[3], 1'h0, eff[4], eff[1], 1'h1, 2'h0, eff});
      wb(1'h0, REG_PIN_STATUS, 32'h0, 4'hF, q);
      check(q, {22'h0, 2'h2, 2'h0, eff});
      pci_rst <= 1'h0;
      repeat (6) @(posedge clk);
      strap <= ~strap;
      repeat (4) @(posedge clk);
      check({l133, h100, depth, stopg},
            {eff[0], !eff[1], eff[2] ? 3'h4 : 3'h1, eff[5]});
      check({valid, flt, rsv, pull},
            {1'h1, !eff[3], eff[1] | eff[4], 1'h0});
      check({pin_oe, pin_o}, {eff[3] ? core_oe : 5'h00, core_o});
      wb(1'h0, REG_STRAP_STATUS, 32'h0, 4'hF, q);
      check(q, exp_q.pop_front());
    end
    wb(1'h1, REG_CLK_CTRL, 32'h11, 4'hE, q);
    wb(1'h0, REG_CLK_CTRL, 32'h0, 4'hF, q);
    check(q, 32'hF0);
    wb(1'h1, REG_CLK_CTRL, 32'h11, 4'hF, q);
    wb(1'h0, REG_CLK_CTRL, 32'h0, 4'hF, q);
    check(q, 32'h11);
    rises = 0;
    lo_prev = lo;
    repeat (16) begin
      @(posedge clk);
      if (lo && !lo_prev) rises++;
      lo_prev = lo;
      check(tx, {lo, lo});
    end
    check(rises, 4);
    check(coe, eff[3]);
    rdata <= 16'($urandom);
    rclk <= 1'h1;
    repeat (8) begin
      @(posedge clk);
      if (rvalid === 1'h1) break;
    end
    check({rvalid, rq}, {1'h1, rdata});
    rclk <= 1'h0;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
